// ---- rtl/mbm_decode.sv ----
// Data address decode onto special registers and general RAM
`timescale 1ns/1ns
module mbm_decode #(
    parameter int RAM_BYTES = mbm_pkg::GPR_BIG
) (
    // Clock and reset, used by the checks only
    input wire logic sys_clk,
    input wire logic reset_n,
    // Full data address
    input wire logic [mbm_pkg::DADDR_W-1:0] addr,
    // Decode result
    output logic is_sfr,
    output logic ram_hit,
    output logic [mbm_pkg::RAM_AW-1:0] ram_idx
);
    localparam int B1_LEN = (RAM_BYTES == mbm_pkg::GPR_BIG) ?
        mbm_pkg::GPR_BANK1_BIG : mbm_pkg::GPR_BANK1_SMALL;
    localparam int B2_BASE = mbm_pkg::GPR_BANK0_LEN + mbm_pkg::GPR_BANK1_BIG;
    localparam int RAM_AW = mbm_pkg::RAM_AW;

    logic [1:0] bank;
    logic [6:0] off;
    logic [6:0] gofs;

    assign bank = addr[8:7];
    assign off = addr[6:0];
    assign gofs = off - mbm_pkg::SFR_COUNT;
    assign is_sfr = off < mbm_pkg::SFR_COUNT;

    always_comb
    begin
        ram_hit = 1'b0;
        ram_idx = '0;
        if (off >= mbm_pkg::COMMON_BASE)
        begin
            // Shared area always lands in bank 0 RAM
            ram_hit = 1'b1;
            ram_idx = RAM_AW'(gofs);
        end
        else if (!is_sfr)
        begin
            case (bank)
                2'h0:
                begin
                    ram_hit = 1'b1;
                    ram_idx = RAM_AW'(gofs);
                end
                2'h1:
                begin
                    ram_hit = 32'(gofs) < B1_LEN;
                    ram_idx = RAM_AW'(32'(gofs) + mbm_pkg::GPR_BANK0_LEN);
                end
                2'h2:
                begin
                    ram_hit = RAM_BYTES == mbm_pkg::GPR_BIG;
                    ram_idx = RAM_AW'(32'(gofs) + B2_BASE);
                end
                default:
                begin
                    ram_hit = 1'b0;
                    ram_idx = '0;
                end
            endcase
        end
    end

    a_sfr_never_ram: assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_sfr |-> !ram_hit) else $error("special register decoded as RAM");
    a_common_mirror: assert property (@(posedge sys_clk) disable iff (!reset_n)
        off >= mbm_pkg::COMMON_BASE |-> ram_hit && ram_idx == RAM_AW'(off - mbm_pkg::SFR_COUNT))
        else $error("common area not mirrored to bank 0");
    a_bank0_gpr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bank == 2'h0 && !is_sfr) |-> ram_hit) else $error("bank 0 RAM not decoded");
    a_ram_size: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ram_hit |-> 32'(ram_idx) < RAM_BYTES) else $error("RAM index beyond size");
    a_bank3_empty: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bank == 2'h3 && !is_sfr && off < mbm_pkg::COMMON_BASE) |-> !ram_hit)
        else $error("bank 3 private RAM decoded");
endmodule

// ---- rtl/mbm_pkg.sv ----
// Constants and register map of the memory bank address map block
// Functional notes
// - Thirteen-bit counter spans 8K instruction words
// - Fetches above implemented words wrap around
// - Reset starts at zero, interrupt loads four
// - Data memory splits into four banks
// - Lowest thirty-two bank locations are special registers
// - Upper ninety-six locations are general RAM in banks 0-2 with 256 bytes; bank 3 has only the top sixteen
// - Top sixteen of banks 1-3 mirror bank 0
// - Unimplemented data locations read as zero
// - Two status bits select the direct bank
// - General RAM is 128 or 256 bytes
// - Direct address or indirect through pointer register
package mbm_pkg;
    localparam int PC_W = 13;
    localparam int PROG_WORDS_DEF = 4096;
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_IRQ = 13'h0004;
    localparam int JUMP_W = 11;
    localparam int FILE_W = 7;
    localparam int DADDR_W = 9;
    localparam int BANK_W = 2;
    localparam logic [6:0] SFR_COUNT = 7'h20;
    localparam logic [6:0] COMMON_BASE = 7'h70;
    // Register indices, as printed, shared by every bank
    localparam logic [6:0] OFF_INDIRECT = 7'h00;
    localparam logic [6:0] OFF_PCL = 7'h02;
    localparam logic [6:0] OFF_STATUS = 7'h03;
    localparam logic [6:0] OFF_FSR = 7'h04;
    localparam logic [6:0] OFF_PROGRAM_COUNTER_UPPER_LATCH = 7'h0a;
    // Status and upper latch field positions
    localparam int STAT_RP_LSB = 5;
    localparam int STAT_IRP_BIT = 7;
    localparam int PROGRAM_COUNTER_UPPER_LATCH_USED_W = 5;
    localparam int PROGRAM_COUNTER_UPPER_LATCH_PAGE_LSB = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // General RAM layout
    localparam int GPR_BIG = 256;
    localparam int GPR_BANK0_LEN = 96;
    localparam int GPR_BANK1_BIG = 80;
    localparam int GPR_BANK1_SMALL = 32;
    localparam int RAM_AW = 8;
    // AXI4-Lite map: byte address is four times the index
    localparam int AXI_AW = 8;
    localparam logic [7:0] AXI_PCL = {OFF_PCL[5:0], 2'b00};
    localparam logic [7:0] AXI_STATUS = {OFF_STATUS[5:0], 2'b00};
    localparam logic [7:0] AXI_FSR = {OFF_FSR[5:0], 2'b00};
    localparam logic [7:0] AXI_PROGRAM_COUNTER_UPPER_LATCH = {OFF_PROGRAM_COUNTER_UPPER_LATCH[5:0], 2'b00};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/mbm_ram.sv ----
// General purpose data RAM with registered read data
`timescale 1ns/1ns
module mbm_ram #(
    parameter int DEPTH = mbm_pkg::GPR_BIG
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Access port
    mbm_ram_if.mem port
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_ff;

    // No reset on the array; contents are undefined until written
    always_ff @(posedge sys_clk)
    begin
        if (port.en && port.we)
            mem_q[port.addr] <= port.wdata;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_ff <= mbm_pkg::REG_RESET;
        else if (port.en && !port.we)
            rdata_ff <= mem_q[port.addr];
    end

    assign port.rdata = rdata_ff;
endmodule

// ---- rtl/mbm_ram_if.sv ----
// Port bundle between the address map and its general RAM
`timescale 1ns/1ns
interface mbm_ram_if;
    logic en;
    logic we;
    logic [mbm_pkg::RAM_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/mbm_top.sv ----
// Program counter, bank select and data address map with AXI4-Lite access
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
module mbm_top #(
    parameter int PROG_WORDS = mbm_pkg::PROG_WORDS_DEF,
    parameter int RAM_BYTES = mbm_pkg::GPR_BIG
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write
    input wire logic [mbm_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [mbm_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core program side
    input wire logic core_step,
    input wire logic core_jump,
    input wire logic [mbm_pkg::JUMP_W-1:0] core_jump_target,
    input wire logic core_irq_take,
    output logic [mbm_pkg::PC_W-1:0] fetch_addr,
    // Core data side
    input wire logic core_data_req,
    input wire logic core_data_we,
    input wire logic [mbm_pkg::FILE_W-1:0] core_file_addr,
    input wire logic [7:0] core_data_wdata,
    output logic [7:0] core_data_rdata,
    output logic core_data_rvalid
);
    localparam logic [12:0] PC_MASK = 13'(PROG_WORDS - 1);

    logic [12:0] pc_ff;
    logic [12:0] nxt_pc;
    logic [12:0] fetch_addr_ff;
    logic [7:0] status_ff;
    logic [7:0] fsr_ff;
    logic [7:0] program_counter_upper_latch_ff;
    logic [8:0] data_addr;
    logic [6:0] off;
    logic is_sfr;
    logic ram_hit;
    logic [7:0] ram_idx;
    logic core_sel;
    logic [7:0] core_val;
    logic core_wr;
    logic core_rd;
    logic rd_pend_ff;
    logic rd_ram_ff;
    logic rd_core_ff;
    logic [7:0] rd_core_val_ff;
    logic [7:0] core_data_rdata_ff;
    logic core_data_rvalid_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic axi_wr;
    logic axi_hit;
    logic [7:0] axi_rval;
    logic axi_rhit;
    logic pcl_wr;
    logic [7:0] pcl_wval;

    mbm_ram_if ram_bus ();

    // Direct: bank bits over file address; file zero goes through pointer
    always_comb
    begin
        if (core_file_addr == mbm_pkg::OFF_INDIRECT)
            data_addr = {status_ff[mbm_pkg::STAT_IRP_BIT], fsr_ff};
        else
            data_addr = {status_ff[mbm_pkg::STAT_RP_LSB +: mbm_pkg::BANK_W],
                core_file_addr};
    end

    assign off = data_addr[6:0];

    mbm_decode #(
        .RAM_BYTES(RAM_BYTES)
    ) u_decode (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .addr(data_addr),
        .is_sfr(is_sfr),
        .ram_hit(ram_hit),
        .ram_idx(ram_idx)
    );

    mbm_ram #(
        .DEPTH(RAM_BYTES)
    ) u_ram (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port(ram_bus.mem)
    );

    // Core registers ignore the bank bits
    always_comb
    begin
        core_sel = 1'b1;
        case (off)
            mbm_pkg::OFF_PCL: core_val = pc_ff[7:0];
            mbm_pkg::OFF_STATUS: core_val = status_ff;
            mbm_pkg::OFF_FSR: core_val = fsr_ff;
            mbm_pkg::OFF_PROGRAM_COUNTER_UPPER_LATCH: core_val = program_counter_upper_latch_ff;
            default:
            begin
                core_sel = 1'b0;
                core_val = '0;
            end
        endcase
    end

    assign core_wr = core_data_req && core_data_we;
    assign core_rd = core_data_req && !core_data_we;
    assign ram_bus.en = core_data_req && ram_hit;
    assign ram_bus.we = core_data_we;
    assign ram_bus.addr = ram_idx;
    assign ram_bus.wdata = core_data_wdata;

    // Read path: stage one captures decode, stage two picks the source
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_pend_ff <= 1'b0;
            rd_ram_ff <= 1'b0;
            rd_core_ff <= 1'b0;
            rd_core_val_ff <= mbm_pkg::REG_RESET;
        end
        else
        begin
            rd_pend_ff <= core_rd;
            rd_ram_ff <= core_rd && ram_hit;
            rd_core_ff <= core_rd && core_sel;
            rd_core_val_ff <= core_val;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            core_data_rdata_ff <= mbm_pkg::REG_RESET;
            core_data_rvalid_ff <= 1'b0;
        end
        else
        begin
            core_data_rvalid_ff <= rd_pend_ff;
            if (rd_ram_ff)
                core_data_rdata_ff <= ram_bus.rdata;
            else if (rd_core_ff)
                core_data_rdata_ff <= rd_core_val_ff;
            else
                core_data_rdata_ff <= '0;
        end
    end

    // Bus write to a core register takes priority over the core's own write
    assign axi_wr = aw_held_ff && w_held_ff && !bvalid_ff;
    assign axi_hit = awaddr_ff == mbm_pkg::AXI_PCL || awaddr_ff == mbm_pkg::AXI_STATUS ||
        awaddr_ff == mbm_pkg::AXI_FSR || awaddr_ff == mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH;

    always_comb
    begin
        pcl_wr = 1'b0;
        pcl_wval = core_data_wdata;
        if (axi_wr && wlane_ff && awaddr_ff == mbm_pkg::AXI_PCL)
        begin
            pcl_wr = 1'b1;
            pcl_wval = wbyte_ff;
        end
        else if (core_wr && core_sel && off == mbm_pkg::OFF_PCL)
            pcl_wr = 1'b1;
    end

    always_comb
    begin
        if (core_irq_take)
            nxt_pc = mbm_pkg::VEC_IRQ;
        else if (pcl_wr)
            nxt_pc = {program_counter_upper_latch_ff[mbm_pkg::PROGRAM_COUNTER_UPPER_LATCH_USED_W-1:0], pcl_wval};
        else if (core_jump)
            nxt_pc = {program_counter_upper_latch_ff[mbm_pkg::PROGRAM_COUNTER_UPPER_LATCH_PAGE_LSB +: 2], core_jump_target};
        else if (core_step)
            nxt_pc = pc_ff + 13'h0001;
        else
            nxt_pc = pc_ff;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_ff <= mbm_pkg::VEC_RESET;
            fetch_addr_ff <= mbm_pkg::VEC_RESET;
        end
        else
        begin
            pc_ff <= nxt_pc;
            fetch_addr_ff <= nxt_pc & PC_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_ff <= mbm_pkg::REG_RESET;
            fsr_ff <= mbm_pkg::REG_RESET;
            program_counter_upper_latch_ff <= mbm_pkg::REG_RESET;
        end
        else if (axi_wr && wlane_ff)
        begin
            if (awaddr_ff == mbm_pkg::AXI_STATUS)
                status_ff <= wbyte_ff;
            if (awaddr_ff == mbm_pkg::AXI_FSR)
                fsr_ff <= wbyte_ff;
            if (awaddr_ff == mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH)
                program_counter_upper_latch_ff <= {3'h0, wbyte_ff[mbm_pkg::PROGRAM_COUNTER_UPPER_LATCH_USED_W-1:0]};
        end
        else if (core_wr && core_sel)
        begin
            if (off == mbm_pkg::OFF_STATUS)
                status_ff <= core_data_wdata;
            if (off == mbm_pkg::OFF_FSR)
                fsr_ff <= core_data_wdata;
            if (off == mbm_pkg::OFF_PROGRAM_COUNTER_UPPER_LATCH)
                program_counter_upper_latch_ff <= {3'h0, core_data_wdata[mbm_pkg::PROGRAM_COUNTER_UPPER_LATCH_USED_W-1:0]};
        end
    end

    // AXI write channel: address and data taken in either order
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= '0;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= mbm_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                awready_ff <= 1'b0;
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff)
            begin
                wready_ff <= 1'b0;
                w_held_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (axi_wr)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= axi_hit ? mbm_pkg::RESP_OKAY : mbm_pkg::RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_comb
    begin
        axi_rhit = 1'b1;
        case (s_axi_araddr)
            mbm_pkg::AXI_PCL: axi_rval = pc_ff[7:0];
            mbm_pkg::AXI_STATUS: axi_rval = status_ff;
            mbm_pkg::AXI_FSR: axi_rval = fsr_ff;
            mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH: axi_rval = program_counter_upper_latch_ff;
            default:
            begin
                axi_rhit = 1'b0;
                axi_rval = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= mbm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, axi_rval};
            rresp_ff <= axi_rhit ? mbm_pkg::RESP_OKAY : mbm_pkg::RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign fetch_addr = fetch_addr_ff;
    assign core_data_rdata = core_data_rdata_ff;
    assign core_data_rvalid = core_data_rvalid_ff;

    a_irq_vector: assert property (@(posedge sys_clk) disable iff (!reset_n)
        core_irq_take |=> pc_ff == mbm_pkg::VEC_IRQ) else $error("interrupt vector not loaded");
    a_pc_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_step && !core_jump && !core_irq_take && !pcl_wr) |=> pc_ff == $past(pc_ff) + 13'h1)
        else $error("program counter did not advance");
    a_fetch_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fetch_addr_ff == (pc_ff & PC_MASK)) else $error("fetch address not wrapped");
    a_direct_bank: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_data_req && core_file_addr != mbm_pkg::OFF_INDIRECT) |->
        data_addr[8:7] == status_ff[6:5] && data_addr[6:0] == core_file_addr)
        else $error("direct address not bank over file");
    a_indirect_ptr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_data_req && core_file_addr == mbm_pkg::OFF_INDIRECT) |->
        data_addr[7:0] == fsr_ff) else $error("indirect address not from pointer");
    a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_rd && !ram_hit && !core_sel) |-> ##2 core_data_rvalid_ff && core_data_rdata_ff == 8'h00)
        else $error("unimplemented location not zero");
    a_core_any_bank: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_rd && off == mbm_pkg::OFF_STATUS) |-> ##2 core_data_rdata_ff == $past(status_ff, 2))
        else $error("status not seen in this bank");
    a_bank_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (core_wr && core_sel && off == mbm_pkg::OFF_STATUS && !axi_wr) |=>
        status_ff == $past(core_data_wdata)) else $error("bank select not written");
endmodule

// ---- tb/mbm_core_model.sv ----
// Core-side model issuing fetch control and data accesses
`timescale 1ns/1ns
module mbm_core_model (
    // Clock
    input wire logic sys_clk,
    // Program side
    output logic core_step,
    output logic core_jump,
    output logic [mbm_pkg::JUMP_W-1:0] core_jump_target,
    output logic core_irq_take,
    // Data side
    output logic core_data_req,
    output logic core_data_we,
    output logic [mbm_pkg::FILE_W-1:0] core_file_addr,
    output logic [7:0] core_data_wdata
);
    initial
    begin
        {core_step, core_jump, core_irq_take, core_data_req, core_data_we} = 5'h00;
        core_jump_target = 11'h000;
        core_file_addr = 7'h00;
        core_data_wdata = 8'h00;
    end

    // Idle cycles before the pulse model a slow core
    task automatic prog(input int idle, input logic s, input logic j, input logic i,
        input logic [10:0] t);
        repeat (idle + 1) @(posedge sys_clk);
        core_step <= s;
        core_jump <= j;
        core_irq_take <= i;
        core_jump_target <= t;
        @(posedge sys_clk);
        core_step <= 1'b0;
        core_jump <= 1'b0;
        core_irq_take <= 1'b0;
    endtask

    task automatic steps(input int n);
        @(posedge sys_clk);
        core_step <= 1'b1;
        repeat (n) @(posedge sys_clk);
        core_step <= 1'b0;
    endtask

    // Write data is inverted on release so stale values never pass as valid
    task automatic data(input logic we, input logic [6:0] f, input logic [7:0] v);
        @(posedge sys_clk);
        core_data_req <= 1'b1;
        core_data_we <= we;
        core_file_addr <= f;
        core_data_wdata <= v;
        @(posedge sys_clk);
        core_data_req <= 1'b0;
        core_data_wdata <= ~v;
    endtask
endmodule

// ---- tb/mbm_top_tb.sv ----
// Self-checking bench for the memory bank address map
`timescale 1ns/1ns
module mbm_top_tb;
    localparam int PW = 1024;
    localparam logic [1:0] OK = mbm_pkg::RESP_OKAY;
    localparam logic [7:0] ST = mbm_pkg::AXI_STATUS;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] strb_sel = 4'h1;
    logic [1:0] bq [$];
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, c_rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [12:0] fetch;
    logic [7:0] c_rdata, dwd;
    logic step, jump, irq, dreq, dwe;
    logic [10:0] tgt;
    logic [6:0] file;
    int mismatches = 0;
    int checks = 0;
    logic [33:0] axq [$];
    logic [7:0] cq [$];
    logic [7:0] d [4];
    logic [7:0] regs [4] = '{mbm_pkg::AXI_PCL, ST, mbm_pkg::AXI_FSR, mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH};

    always #25 sys_clk = ~sys_clk;

    mbm_top #(.PROG_WORDS(PW), .RAM_BYTES(256)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_step(step), .core_jump(jump),
        .core_jump_target(tgt), .core_irq_take(irq), .fetch_addr(fetch),
        .core_data_req(dreq), .core_data_we(dwe), .core_file_addr(file),
        .core_data_wdata(dwd), .core_data_rdata(c_rdata), .core_data_rvalid(c_rvalid));

    mbm_core_model core_u (.sys_clk(sys_clk), .core_step(step), .core_jump(jump),
        .core_jump_target(tgt), .core_irq_take(irq), .core_data_req(dreq),
        .core_data_we(dwe), .core_file_addr(file), .core_data_wdata(dwd));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
        int n;
        n = 0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= strb_sel;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && n < 40);
        tmo(n);
        bready <= 1'b0;
        // One idle edge so the next call never re-raises in this step
        @(posedge sys_clk);
    endtask

    // Expected word is noted first; the monitor below compares it
    task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
        int n;
        n = 0;
        axq.push_back({r, 24'h0, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && n < 40);
        tmo(n);
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic crd(input logic [6:0] f, input logic [7:0] e);
        cq.push_back(e);
        core_u.data(1'b0, f, 8'h00);
    endtask

    task automatic fchk(input logic [12:0] pc);
        #1;
        chk({21'h0, fetch}, {21'h0, pc & 13'(PW - 1)});
    endtask

    always @(posedge sys_clk)
    begin
        if (rvalid && rready)
            chk({rresp, rdata}, (axq.size() > 0) ? axq.pop_front() : 34'h3_ffff_ffff);
        if (bvalid && bready)
            chk({32'h0, bresp}, (bq.size() > 0) ? {32'h0, bq.pop_front()} : 34'h3_ffff_ffff);
        if (c_rvalid)
            chk({26'h0, c_rdata}, (cq.size() > 0) ? {26'h0, cq.pop_front()} : 34'h1_0000_0000);
    end

    initial
    begin
        void'($urandom(77));
        repeat (20) @(posedge sys_clk);
        fchk(13'h0000);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (regs[i])
            axi_rd(regs[i], 8'h00, OK);
        axi_rd(8'h04, 8'h00, mbm_pkg::RESP_SLVERR);
        axi_wr(8'h04, 8'h55, mbm_pkg::RESP_SLVERR);
        core_u.steps(5);
        fchk(13'h0005);
        core_u.prog(2, 1'b1, 1'b1, 1'b1, 11'h7ff);
        fchk(13'h0004);
        axi_wr(mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH, 8'h18, OK);
        core_u.prog(0, 1'b0, 1'b1, 1'b0, 11'h7ff);
        fchk(13'h1fff);
        core_u.steps(1);
        fchk(13'h0000);
        axi_wr(mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH, 8'he5, OK);
        axi_rd(mbm_pkg::AXI_PROGRAM_COUNTER_UPPER_LATCH, 8'h05, OK);
        axi_wr(mbm_pkg::AXI_PCL, 8'h34, OK);
        fchk(13'h0534);
        axi_rd(mbm_pkg::AXI_PCL, 8'h34, OK);
        foreach (d[b])
        begin
            d[b] = 8'($urandom);
            axi_wr(ST, {1'b0, 2'(b), 5'h00}, OK);
            core_u.data(1'b1, 7'h20, d[b]);
            core_u.data(1'b1, 7'h60, ~d[b]);
        end
        // Written from bank 3, must land in the shared area of bank 0
        core_u.data(1'b1, 7'h75, d[0]);
        foreach (d[b])
        begin
            axi_wr(ST, {1'b0, 2'(b), 5'h00}, OK);
            crd(7'h20, (b == 3) ? 8'h00 : d[b]);
            crd(7'h75, d[0]);
            crd(7'h03, {1'b0, 2'(b), 5'h00});
            crd(7'h05, 8'h00);
            crd(7'h60, (b == 3) ? 8'h00 : ~d[b]);
        end
        axi_wr(ST, 8'h00, OK);
        core_u.data(1'b1, 7'h04, 8'ha0);
        crd(7'h00, d[1]);
        axi_wr(ST, 8'h80, OK);
        crd(7'h00, 8'h00);
        core_u.data(1'b1, 7'h04, 8'h20);
        crd(7'h00, d[2]);
        core_u.data(1'b1, 7'h00, 8'h5a);
        axi_rd(mbm_pkg::AXI_FSR, 8'h20, OK);
        axi_wr(ST, 8'h40, OK);
        crd(7'h20, 8'h5a);
        // Byte lane off: write answered but status must keep its value
        strb_sel = 4'h0;
        axi_wr(ST, 8'hff, OK);
        axi_rd(ST, 8'h40, OK);
        strb_sel = 4'h1;
        repeat (4) @(posedge sys_clk);
        chk(34'(axq.size() + cq.size() + bq.size()), 34'h0);
        end_of_test();
    end
endmodule
